// [verilog/msfg_guard.sv]
// Purpose: frequent start protection with start-stress counter and AXI4-Lite settings
// Assumes: current and thermal level come from logic on aclk
// Notes:   counter unit is 0.1 s of stall time times one program cycle
`timescale 1ns/1ps
`include "msfg_cfg.svh"
module msfg_guard import msfg_pkg::*; #(
  parameter logic [21:0] CYCLE_CLKS   = 22'(`MSFG_CYCLE_CLKS),
  parameter logic [18:0] CYC_PER_HOUR = 19'(`MSFG_CYC_PER_HOUR)
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // measurements
  input  wire logic [15:0] motor_current,
  input  wire logic [9:0]  thermal_level,
  // protection outputs
  output logic             motor_start_detect,
  output logic             start_alarm,
  output logic             restart_inhibit,
  output logic [1:0]       guard_condition
);

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    msfg_mode_t  guard_function_mode;
    logic [31:0] r_stall;
    logic [31:0] r_starts;
    logic [31:0] r_limits;
    logic [31:0] r_level;
    logic [21:0] tick_cnt;
    logic        tick;
    logic        running;
    logic        start_det;
    logic [47:0] cnt;
    logic [15:0] gap;
    msfg_phase_t phase;
    logic        launched;
    logic        div_go;
    logic [47:0] div_a;
    logic [47:0] div_b;
    logic [6:0]  used;
    logic [6:0]  avail;
    logic [31:0] inh_time;
    logic [31:0] alm_time;
    logic        hot;
    logic        alarm;
    logic        inhibit;
    msfg_cond_t  cond;
    msfg_mode_t  guard_active_mode;
  } msfg_state_t;

  localparam msfg_state_t ST_RESET = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1,
    guard_function_mode: MSFG_MODE_ON, guard_active_mode: MSFG_MODE_ON,
    r_stall: `MSFG_RST_STALL, r_starts: `MSFG_RST_STARTS,
    r_limits: `MSFG_RST_LIMITS, r_level: `MSFG_RST_LEVEL,
    gap: 16'hffff, cond: MSFG_COND_NORMAL, phase: MSFG_PH_IDLE,
    default: '0
  };

  msfg_state_t st_reg;
  msfg_state_t st_next;

  logic [31:0] wmask;
  logic [47:0] quo;
  logic        div_done;

  // byte lane mask from the held strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{st_reg.w_strb[gi]}};
    end
  endgenerate

  msfg_div u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .go       (st_reg.div_go),
    .dividend (st_reg.div_a),
    .divisor  (st_reg.div_b),
    .quotient (quo),
    .done     (div_done)
  );

  // settings in working form
  logic [12:0] stall_app;
  logic [6:0]  n_raw;
  logic [6:0]  n_eff;
  logic [25:0] win;
  logic [47:0] quantum;
  logic [47:0] lim1;
  logic [47:0] lim2;
  logic [15:0] gap_min;
  logic        hot_now;
  logic        over;
  logic        one_left;
  logic        gap_block;
  logic        blocked_mode;
  logic        off_mode;
  logic [31:0] merged;
  logic [31:0] status_word;

  always_comb begin
    hot_now   = thermal_level > st_reg.r_limits[`MSFG_F_HOT_LIMIT];
    // hot picks hot stall and count, else cold rate applies
    stall_app = hot_now ? st_reg.r_stall[`MSFG_F_STALL_HOT]
                        : st_reg.r_stall[`MSFG_F_STALL_COLD];
    n_raw     = hot_now ? st_reg.r_starts[`MSFG_F_STARTS_HOT]
                        : st_reg.r_starts[`MSFG_F_STARTS_COLD];
    n_eff     = (n_raw == 7'h00) ? 7'h01 : n_raw;
    win       = 26'(st_reg.r_starts[`MSFG_F_HOURS]) * 26'(CYC_PER_HOUR);
    // quantum independent of actual start length
    quantum   = 48'(stall_app) * 48'(win);
    lim1      = 48'(n_eff - 7'h01) * quantum;
    lim2      = (n_eff >= 7'h02) ? 48'(n_eff - 7'h02) * quantum : 48'h0;
    gap_min   = 16'(st_reg.r_limits[`MSFG_F_MIN_BETW] * `MSFG_CYC_PER_TENTH);
    over      = st_reg.cnt > lim1;
    one_left  = !over && (n_eff < 7'h02 || st_reg.cnt > lim2);
    gap_block = st_reg.gap < gap_min;
    blocked_mode = st_reg.guard_function_mode == MSFG_MODE_BLOCKED ||
                   st_reg.guard_function_mode == MSFG_MODE_TEST_BLOCKED;
    off_mode  = st_reg.guard_function_mode == MSFG_MODE_OFF;
    merged    = (32'h0 & ~wmask) | (st_reg.w_data & wmask);
    status_word = {1'b0, st_reg.avail, 1'b0, st_reg.used, 5'h00,
                   st_reg.guard_active_mode, 2'h0, st_reg.cond,
                   st_reg.running, st_reg.hot, st_reg.inhibit, st_reg.alarm};
  end

  // all next-state logic
  always_comb begin
    logic        wr_ok;
    logic [31:0] wold;
    logic [31:0] wnew;
    logic [47:0] dec;
    logic [47:0] c1;
    wr_ok = 1'b1;
    wold  = 32'h0;
    wnew  = 32'h0;
    dec   = 48'h0;
    c1    = 48'h0;
    st_next = st_reg;
    st_next.tick   = 1'b0;
    st_next.div_go = 1'b0;

    // write channel: address and data in either order
    if (awvalid && st_reg.awready) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = awaddr;
      st_next.awready = 1'b0;
    end
    if (wvalid && st_reg.wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = wdata;
      st_next.w_strb = wstrb;
      st_next.wready = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      unique case (st_reg.aw_addr)
        `MSFG_OFS_MODE:     wold = {29'h0, st_reg.guard_function_mode};
        `MSFG_OFS_STALL:    wold = st_reg.r_stall;
        `MSFG_OFS_STARTS:   wold = st_reg.r_starts;
        `MSFG_OFS_LIMITS:   wold = st_reg.r_limits;
        `MSFG_OFS_LEVEL:    wold = st_reg.r_level;
        `MSFG_OFS_STATUS,
        `MSFG_OFS_INH_TIME,
        `MSFG_OFS_ALM_TIME: wold = 32'h0;
        default:            wr_ok = 1'b0;
      endcase
      wnew = (wold & ~wmask) | merged;
      unique case (st_reg.aw_addr)
        // mode lives outside the setting banks, codes above 4 ignored
        `MSFG_OFS_MODE: begin
          if (wnew[`MSFG_F_MODE] <= `MSFG_MODE_MAX) begin
            st_next.guard_function_mode = msfg_mode_t'(wnew[`MSFG_F_MODE]);
          end
        end
        `MSFG_OFS_STALL:  st_next.r_stall  = wnew & 32'h1fff1fff;
        `MSFG_OFS_STARTS: st_next.r_starts = wnew & 32'h007f7f7f;
        `MSFG_OFS_LIMITS: st_next.r_limits = wnew & 32'h1fff03ff;
        `MSFG_OFS_LEVEL:  st_next.r_level  = wnew;
        default: ;
      endcase
      st_next.bvalid = 1'b1;
      st_next.bresp  = wr_ok ? `MSFG_RESP_OKAY : `MSFG_RESP_SLVERR;
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end

    // read channel, data captured at address handshake
    if (arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = `MSFG_RESP_OKAY;
      unique case (araddr)
        `MSFG_OFS_MODE:     st_next.rdata = {29'h0, st_reg.guard_function_mode};
        `MSFG_OFS_STALL:    st_next.rdata = st_reg.r_stall;
        `MSFG_OFS_STARTS:   st_next.rdata = st_reg.r_starts;
        `MSFG_OFS_LIMITS:   st_next.rdata = st_reg.r_limits;
        `MSFG_OFS_LEVEL:    st_next.rdata = st_reg.r_level;
        `MSFG_OFS_STATUS:   st_next.rdata = status_word;
        `MSFG_OFS_INH_TIME: st_next.rdata = st_reg.inh_time;
        `MSFG_OFS_ALM_TIME: st_next.rdata = st_reg.alm_time;
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = `MSFG_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end

    // program cycle timebase
    if (st_reg.tick_cnt >= CYCLE_CLKS - 22'h1) begin
      st_next.tick_cnt = 22'h0;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 22'h1;
    end

    // start seen when current crosses start level from standstill
    st_next.start_det = !st_reg.running && !off_mode &&
                        motor_current >= st_reg.r_level[`MSFG_F_LVL_START];
    if (st_next.start_det) begin
      st_next.running = 1'b1;
    end else if (motor_current < st_reg.r_level[`MSFG_F_LVL_STOP]) begin
      st_next.running = 1'b0;
    end

    // decay each program cycle, floored at zero
    dec = st_reg.tick ? 48'(stall_app) : 48'h0;
    c1  = (st_reg.cnt > dec) ? st_reg.cnt - dec : 48'h0;
    // attempts count too, even while inhibited
    if (st_reg.start_det) begin
      c1 = c1 + quantum;
    end
    st_next.cnt = off_mode ? 48'h0 : c1;

    // spacing timer in program cycles, saturating
    if (st_reg.start_det) begin
      st_next.gap = 16'h0;
    end else if (st_reg.tick && st_reg.gap != 16'hffff) begin
      st_next.gap = st_reg.gap + 16'h1;
    end

    // read-outs refreshed once per program cycle through the divider
    unique case (st_reg.phase)
      MSFG_PH_IDLE: begin
        if (st_reg.tick) begin
          st_next.phase    = MSFG_PH_USED;
          st_next.launched = 1'b0;
        end
      end
      MSFG_PH_USED: begin
        if (!st_reg.launched) begin
          st_next.div_go   = 1'b1;
          st_next.div_a    = st_reg.cnt + quantum - 48'h1;
          st_next.div_b    = quantum;
          st_next.launched = 1'b1;
        end else if (div_done) begin
          st_next.used     = (quo > 48'h7f) ? 7'h7f : quo[6:0];
          st_next.phase    = MSFG_PH_INH;
          st_next.launched = 1'b0;
        end
      end
      MSFG_PH_INH: begin
        if (!st_reg.launched) begin
          st_next.div_go   = 1'b1;
          st_next.div_a    = over ? st_reg.cnt - lim1 : 48'h0;
          st_next.div_b    = 48'(stall_app);
          st_next.launched = 1'b1;
        end else if (div_done) begin
          // longer of budget wait and spacing wait
          if (gap_block && 48'(gap_min - st_reg.gap) > quo) begin
            st_next.inh_time = 32'(gap_min - st_reg.gap);
          end else begin
            st_next.inh_time = (quo[47:32] != 16'h0) ? 32'hffffffff : quo[31:0];
          end
          st_next.phase    = MSFG_PH_ALM;
          st_next.launched = 1'b0;
        end
      end
      MSFG_PH_ALM: begin
        if (!st_reg.launched) begin
          st_next.div_go   = 1'b1;
          st_next.div_a    = (n_eff >= 7'h02 && st_reg.cnt > lim2) ? st_reg.cnt - lim2 : 48'h0;
          st_next.div_b    = 48'(stall_app);
          st_next.launched = 1'b1;
        end else if (div_done) begin
          st_next.alm_time = (quo[47:32] != 16'h0) ? 32'hffffffff : quo[31:0];
          st_next.avail    = (n_eff > st_reg.used) ? n_eff - st_reg.used : 7'h00;
          st_next.phase    = MSFG_PH_IDLE;
        end
      end
    endcase

    // protection outputs and mode gating
    st_next.hot               = hot_now;
    st_next.guard_active_mode = st_reg.guard_function_mode;
    st_next.alarm   = one_left && !blocked_mode && !off_mode;
    // hot or cold allowance picked anew each clock, so inhibit can drop when cooling
    st_next.inhibit = (over || gap_block) && !blocked_mode && !off_mode;
    if (off_mode) begin
      st_next.cond = MSFG_COND_NORMAL;
    end else if (blocked_mode && (one_left || over || gap_block)) begin
      st_next.cond = MSFG_COND_BLOCKED;
    end else if (over || gap_block) begin
      st_next.cond = MSFG_COND_TRIP;
    end else if (one_left) begin
      st_next.cond = MSFG_COND_START;
    end else begin
      st_next.cond = MSFG_COND_NORMAL;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign awready            = st_reg.awready;
  assign wready             = st_reg.wready;
  assign bvalid             = st_reg.bvalid;
  assign bresp              = st_reg.bresp;
  assign arready            = st_reg.arready;
  assign rvalid             = st_reg.rvalid;
  assign rresp              = st_reg.rresp;
  assign rdata              = st_reg.rdata;
  assign motor_start_detect = st_reg.start_det;
  assign start_alarm        = st_reg.alarm;
  assign restart_inhibit    = st_reg.inhibit;
  assign guard_condition    = st_reg.cond;

endmodule // msfg_guard

// [pkg/msfg_cfg.svh]
// Purpose: constants of the motor start frequency guard
// Assumes: included by bare name wherever a figure is needed
// Notes:   settings are in 0.1 s, 0.1 % and 0.01 x nominal current units
`ifndef MSFG_CFG_SVH
`define MSFG_CFG_SVH

// timing
`define MSFG_CLK_MHZ        250
`define MSFG_CYCLE_MS       10
`define MSFG_CYCLE_CLKS     (`MSFG_CYCLE_MS * 1000 * `MSFG_CLK_MHZ)
`define MSFG_CYC_PER_HOUR   (3600 * 1000 / `MSFG_CYCLE_MS)
`define MSFG_CYC_PER_TENTH  (100 / `MSFG_CYCLE_MS)

// register byte offsets
`define MSFG_OFS_MODE       8'h00
`define MSFG_OFS_STALL      8'h04
`define MSFG_OFS_STARTS     8'h08
`define MSFG_OFS_LIMITS     8'h0c
`define MSFG_OFS_LEVEL      8'h10
`define MSFG_OFS_STATUS     8'h14
`define MSFG_OFS_INH_TIME   8'h18
`define MSFG_OFS_ALM_TIME   8'h1c

// field positions
`define MSFG_F_MODE         2:0
`define MSFG_F_STALL_COLD   12:0
`define MSFG_F_STALL_HOT    28:16
`define MSFG_F_STARTS_COLD  6:0
`define MSFG_F_STARTS_HOT   14:8
`define MSFG_F_HOURS        22:16
`define MSFG_F_HOT_LIMIT    9:0
`define MSFG_F_MIN_BETW     28:16
`define MSFG_F_LVL_START    15:0
`define MSFG_F_LVL_STOP     31:16

// reset values, mode limit and bus response codes
`define MSFG_RST_STALL      {3'h0, 13'h096, 3'h0, 13'h0c8}
`define MSFG_RST_STARTS     {9'h000, 7'h01, 1'b0, 7'h02, 1'b0, 7'h03}
`define MSFG_RST_LIMITS     {3'h0, 13'h0c8, 6'h00, 10'h2bc}
`define MSFG_RST_LEVEL      {16'h000a, 16'h0096}
`define MSFG_MODE_MAX       3'h4
`define MSFG_RESP_OKAY      2'h0
`define MSFG_RESP_SLVERR    2'h2

`endif

// [pkg/msfg_pkg.sv]
// Purpose: types of the motor start frequency guard
// Assumes: nothing
// Notes:   mode codes follow list order, On first
package msfg_pkg;

  typedef enum logic [2:0] {
    MSFG_MODE_ON, MSFG_MODE_BLOCKED, MSFG_MODE_TEST, MSFG_MODE_TEST_BLOCKED, MSFG_MODE_OFF
  } msfg_mode_t;

  typedef enum logic [1:0] {
    MSFG_COND_NORMAL, MSFG_COND_START, MSFG_COND_TRIP, MSFG_COND_BLOCKED
  } msfg_cond_t;

  typedef enum logic [1:0] {
    MSFG_PH_IDLE, MSFG_PH_USED, MSFG_PH_INH, MSFG_PH_ALM
  } msfg_phase_t;

endpackage

// [verilog/msfg_div.sv]
// Purpose: serial 48-bit unsigned divider for the guard read-outs
// Assumes: go pulses with operands stable on the same edge
// Notes:   48 steps; divide by zero yields all ones
`timescale 1ns/1ps
module msfg_div import msfg_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // request
  input  wire logic        go,
  input  wire logic [47:0] dividend,
  input  wire logic [47:0] divisor,
  // answer
  output logic      [47:0] quotient,
  output logic             done
);

  typedef struct packed {
    logic        busy;
    logic [5:0]  steps;
    logic [47:0] rem;
    logic [47:0] quo;
    logic [47:0] dvs;
    logic [47:0] result;
    logic        done;
  } msfg_div_state_t;

  msfg_div_state_t st_reg;
  msfg_div_state_t st_next;
  logic [48:0]     trial;

  // one restoring step per clock
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    trial = {st_reg.rem, st_reg.quo[47]};
    if (go) begin
      st_next.busy  = 1'b1;
      st_next.steps = 6'h30;
      st_next.rem   = 48'h0;
      st_next.quo   = dividend;
      st_next.dvs   = divisor;
    end else if (st_reg.busy) begin
      if (trial >= {1'b0, st_reg.dvs}) begin
        st_next.rem = 48'(trial - {1'b0, st_reg.dvs});
        st_next.quo = {st_reg.quo[46:0], 1'b1};
      end else begin
        st_next.rem = trial[47:0];
        st_next.quo = {st_reg.quo[46:0], 1'b0};
      end
      st_next.steps = st_reg.steps - 6'h01;
      if (st_reg.steps == 6'h01) begin
        st_next.busy   = 1'b0;
        st_next.done   = 1'b1;
        st_next.result = st_next.quo;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign quotient = st_reg.result;
  assign done     = st_reg.done;

endmodule // msfg_div

// [tb/msfg_guard_assertions.sv]
// Purpose: port-level checks of the start guard
// Assumes: bound to msfg_guard, one clock domain, start level left at reset
// Notes:   counter itself is hidden, so checks tie outputs to each other
`timescale 1ns/1ps
module msfg_guard_assertions import msfg_pkg::*; #(
  parameter logic [21:0] CYCLE_CLKS   = 22'h000014,
  parameter logic [18:0] CYC_PER_HOUR = 19'h00032,
  parameter logic [15:0] START_LEVEL  = 16'h0096
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // bus answers
  input  wire logic        bready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  input  wire logic        rready,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  // protection
  input  wire logic [15:0] motor_current,
  input  wire logic        motor_start_detect,
  input  wire logic        start_alarm,
  input  wire logic        restart_inhibit,
  input  wire logic [1:0]  guard_condition
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a start is one pulse, caused by current above the start level
  detect_pulse_a: assert property (motor_start_detect |=> !motor_start_detect)
    else $error("start indication longer than one cycle");
  detect_level_a: assert property (motor_start_detect |-> $past(motor_current) >= START_LEVEL)
    else $error("start indicated below start level");
  // a fresh start always blocks the next one, or is shown as blocked
  spacing_block_a: assert property (motor_start_detect |-> ##2
    (restart_inhibit || guard_condition == MSFG_COND_BLOCKED))
    else $error("start not followed by spacing block");
  // condition code follows the outputs
  trip_cond_a: assert property (restart_inhibit |-> guard_condition == MSFG_COND_TRIP)
    else $error("inhibit without trip condition");
  start_cond_a: assert property (start_alarm && !restart_inhibit |-> guard_condition == MSFG_COND_START)
    else $error("alarm without start condition");
  blocked_quiet_a: assert property (guard_condition == MSFG_COND_BLOCKED |-> !start_alarm && !restart_inhibit)
    else $error("blocked condition with live outputs");
  reset_quiet_a: assert property ($rose(aresetn) |-> !start_alarm && !restart_inhibit && guard_condition == MSFG_COND_NORMAL)
    else $error("outputs active after reset");
  // bus answers stay put until taken
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
endmodule // msfg_guard_assertions

bind msfg_guard msfg_guard_assertions #(.CYCLE_CLKS(CYCLE_CLKS), .CYC_PER_HOUR(CYC_PER_HOUR))
  i_msfg_guard_assertions (.aclk(aclk), .aresetn(aresetn), .bready(bready), .bresp(bresp),
  .bvalid(bvalid), .rready(rready), .rdata(rdata), .rvalid(rvalid),
  .motor_current(motor_current), .motor_start_detect(motor_start_detect),
  .start_alarm(start_alarm), .restart_inhibit(restart_inhibit),
  .guard_condition(guard_condition));

// [tb/msfg_motor_model.sv]
// Purpose: motor and thermal overload stand-in
// Assumes: bench sets run and hot just after a clock edge
// Notes:   levels sit either side of the default hot limit
`timescale 1ns/1ps
module msfg_motor_model (
  // control from bench
  input  wire logic        aclk,
  input  wire logic        run,
  input  wire logic        hot,
  // measurements to guard
  output logic      [15:0] motor_current,
  output logic      [9:0]  thermal_level
);
  // registered so the guard only ever sees clean steps; settles while reset holds
  always @(posedge aclk) begin
    motor_current <= run ? 16'h0200 : 16'h0000;
    thermal_level <= hot ? 10'h320 : 10'h064;
  end
endmodule // msfg_motor_model

// [tb/msfg_guard_tb.sv]
// Purpose: self-checking bench of the start guard
// Assumes: program cycle cut to 20 clocks, one hour to 50 cycles
// Notes:   start spacing set to 0.1 s, so one gap is 200 clocks
`timescale 1ns/1ps
`include "msfg_cfg.svh"
module msfg_guard_tb import msfg_pkg::*;;
  logic        aclk, aresetn, run, hot, seen;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] motor_current;
  logic [9:0]  thermal_level;
  logic        motor_start_detect, start_alarm, restart_inhibit;
  logic [1:0]  guard_condition;
  int          error_cnt, checked;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  msfg_guard #(.CYCLE_CLKS(22'h000014), .CYC_PER_HOUR(19'h00032)) i_msfg_guard (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .motor_current(motor_current), .thermal_level(thermal_level),
    .motor_start_detect(motor_start_detect), .start_alarm(start_alarm),
    .restart_inhibit(restart_inhibit), .guard_condition(guard_condition));

  msfg_motor_model i_msfg_motor_model (.aclk(aclk), .run(run), .hot(hot),
    .motor_current(motor_current), .thermal_level(thermal_level));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic timed_out(input string nm);
    error_cnt++;
    $display("ERROR %s expected answer seen timeout", nm);
    report_and_stop();
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // ready raised only once the answer shows, so the hold checks get exercised
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    if (n == 50) timed_out("write answer");
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    if (n == 50) timed_out("read answer");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // short run pulse; returns two edges after the indication
  task automatic start_motor(output logic s);
    int n;
    s = 1'b0;
    @(posedge aclk);
    run <= 1'b1;
    for (n = 0; n < 8 && !s; n++) begin
      @(posedge aclk);
      s = (motor_start_detect === 1'b1);
    end
    wait_clk(2);
    run <= 1'b0;
  endtask

  task automatic t_reset();
    axi_rd(`MSFG_OFS_MODE, rd, rsp);
    check("mode after reset", 32'h00000000, rd);
    axi_rd(`MSFG_OFS_STARTS, rd, rsp);
    check("start counts", `MSFG_RST_STARTS, rd);
    axi_rd(8'h40, rd, rsp);
    check("unmapped resp", {30'h0, `MSFG_RESP_SLVERR}, {30'h0, rsp});
    axi_wr(`MSFG_OFS_LIMITS, 32'h000102bc, rsp);
    check("limits resp", {30'h0, `MSFG_RESP_OKAY}, {30'h0, rsp});
  endtask

  task automatic t_spacing();
    start_motor(seen);
    check("start seen", 32'h1, {31'h0, seen});
    check("spacing inhibit", 32'h1, {31'h0, restart_inhibit});
    check("trip cond", {30'h0, MSFG_COND_TRIP}, {30'h0, guard_condition});
    wait_clk(240);
    check("inhibit after gap", 32'h0, {31'h0, restart_inhibit});
    check("alarm one used", 32'h0, {31'h0, start_alarm});
  endtask

  task automatic t_budget();
    int n;
    start_motor(seen);
    // read-outs lag the counter by up to two serial passes, so wait past both
    wait_clk(340);
    check("alarm one left", 32'h1, {31'h0, start_alarm});
    check("no inhibit", 32'h0, {31'h0, restart_inhibit});
    axi_rd(`MSFG_OFS_STATUS, rd, rsp);
    check("used starts", 32'h2, {25'h0, rd[22:16]});
    check("free starts", 32'h1, {25'h0, rd[30:24]});
    start_motor(seen);
    wait_clk(240);
    check("budget inhibit", 32'h1, {31'h0, restart_inhibit});
    for (n = 0; n < 600 && restart_inhibit === 1'b1; n++) @(posedge aclk);
    if (n == 600) timed_out("inhibit release");
    check("alarm after decay", 32'h1, {31'h0, start_alarm});
  endtask

  task automatic t_hot();
    wait_clk(2200);
    hot <= 1'b1;
    wait_clk(5);
    axi_rd(`MSFG_OFS_STATUS, rd, rsp);
    check("hot flag", 32'h1, {31'h0, rd[2]});
    check("alarm idle", 32'h0, {31'h0, start_alarm});
    start_motor(seen);
    wait_clk(240);
    check("hot alarm", 32'h1, {31'h0, start_alarm});
    hot <= 1'b0;
    wait_clk(5);
    check("cold alarm", 32'h0, {31'h0, start_alarm});
  endtask

  task automatic t_modes();
    int m;
    for (m = 0; m < 5; m++) begin
      axi_wr(`MSFG_OFS_MODE, 32'(m), rsp);
      axi_rd(`MSFG_OFS_STATUS, rd, rsp);
      check("active mode", 32'(m), {29'h0, rd[10:8]});
    end
    start_motor(seen);
    check("off start", 32'h0, {31'h0, seen});
    axi_wr(`MSFG_OFS_MODE, {29'h0, MSFG_MODE_BLOCKED}, rsp);
    start_motor(seen);
    check("blocked start", 32'h1, {31'h0, seen});
    check("blocked inhibit", 32'h0, {31'h0, restart_inhibit});
    check("blocked cond", {30'h0, MSFG_COND_BLOCKED}, {30'h0, guard_condition});
  endtask

  // stimulus
  initial begin
    error_cnt = 0;
    checked = 0;
    aresetn = 1'b0;
    {run, hot, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    wait_clk(2);
    aresetn <= 1'b1;
    t_reset();
    t_spacing();
    t_budget();
    t_hot();
    t_modes();
    report_and_stop();
  end
endmodule // msfg_guard_tb
